// File: sata_lpm_pkg.sv
// Constants and types for the port link power manager.
// Assumes one clock domain and plain-port control from the register file.
package sata_lpm_pkg;

	// Interface communication control codes written by software.
	localparam logic [3:0] ICC_IDLE    = 4'h0;
	localparam logic [3:0] ICC_ACTIVE  = 4'h1;
	localparam logic [3:0] ICC_PARTIAL = 4'h2;
	localparam logic [3:0] ICC_SLUMBER = 4'h6;

	// Allowed power transition codes.
	localparam logic [3:0] IPM_ALLOW_ALL  = 4'h0;
	localparam logic [3:0] IPM_NO_PARTIAL = 4'h1;
	localparam logic [3:0] IPM_NO_SLUMBER = 4'h2;
	localparam logic [3:0] IPM_NO_ANY     = 4'h3;

	// Reported link power state codes.
	localparam logic [3:0] RPT_ACTIVE  = 4'h1;
	localparam logic [3:0] RPT_PARTIAL = 4'h2;
	localparam logic [3:0] RPT_SLUMBER = 4'h6;

	// Values after reset.
	localparam logic [3:0] RST_REPORT = 4'h1;
	localparam logic       RST_TARGET = 1'b0;
	localparam logic       RST_D3     = 1'b0;

	typedef enum logic [3:0] {
		LNK_ACTIVE  = 4'h1,
		LNK_REQUEST = 4'h2,
		LNK_LOW     = 4'h4,
		LNK_WAKE    = 4'h8
	} link_state_type;

endpackage : sata_lpm_pkg

// File: sata_port_link_power_manager.sv
// Link and adapter power management for one port of the host adapter.
// Assumes the link layer, command engine and config space share clk_sys.
//
// Notes on behaviour
// - Aggressive enable plus idle starts low-power entry.
// - Idle when adapter empties issued bitmap.
// - Idle when set-bits FIS empties active bitmap.
// - Already-idle link never self-enters low power.
// - Wake link with COMWAKE before sending FIS.
// - Adapter request beats simultaneous software request.
// - Software slumber code requests slumber state.
// - In D3, register space accesses master abort.
// - In D3, interrupts are suppressed.
// - Config write leaves D3hot; reset leaves D3cold.
// - In D3, wake events assert PME.
// - Optionally require notification bit for wake.
// - Report aggressive support; enable and select gate.
// - Report port multiplier support; command switching.
// - Software request ignored unless link idle.
// - Allowed field 3h blocks, 0h allows.
module sata_port_link_power_manager
	import sata_lpm_pkg::*;
#(
	parameter bit AGGR_SUPPORTED  = 1'b1,
	parameter bit PARTIAL_CAP     = 1'b1,
	parameter bit SLUMBER_CAP     = 1'b1,
	parameter bit PMULT_SUPPORTED = 1'b1,
	parameter bit WAKE_NEEDS_NOTE = 1'b0,
	parameter int TAG_COUNT       = 32
) (
	input  wire logic                 clk_sys,
	input  wire logic                 arst_n,
	output      logic                 aggressive_pm_supported,
	output      logic                 partial_capable,
	output      logic                 slumber_capable,
	output      logic                 port_multiplier_supported,
	output      logic                 command_based_switching,
	input  wire logic                 aggressive_pm_enable,
	input  wire logic                 aggressive_state_select,
	input  wire logic [3:0]           allowed_power_transitions,
	input  wire logic [3:0]           interface_comm_control,
	input  wire logic                 icc_write,
	input  wire logic [TAG_COUNT-1:0] active_tag_bitmap,
	input  wire logic [TAG_COUNT-1:0] issued_command_bitmap,
	input  wire logic                 sdb_received,
	input  wire logic                 sdb_interrupt_bit,
	input  wire logic                 sdb_notify_bit,
	input  wire logic                 link_idle,
	input  wire logic                 link_active,
	input  wire logic                 pm_ack,
	input  wire logic                 pm_nack,
	output      logic                 pm_request,
	output      logic                 pm_request_slumber,
	output      logic                 comwake_request,
	output      logic [3:0]           link_pm_report,
	input  wire logic                 fis_tx_request,
	output      logic                 fis_tx_go,
	input  wire logic                 pmcsr_write,
	input  wire logic                 pmcsr_d3,
	output      logic                 power_d3,
	input  wire logic                 mmio_access,
	output      logic                 mmio_accept,
	output      logic                 mmio_master_abort,
	input  wire logic                 global_interrupt_enable,
	input  wire logic                 port_irq_pending,
	output      logic                 irq_out,
	input  wire logic                 hotplug_insert_change,
	input  wire logic                 presence_switch_change,
	input  wire logic                 cold_presence_change,
	input  wire logic                 pme_status_clear,
	output      logic                 pme_status,
	output      logic                 pme_n_out,
	output      logic                 pme_n_oe
);

	link_state_type       state_q;
	logic                 target_q;
	logic                 aggr_pend_q;
	logic [TAG_COUNT-1:0] issued_q;
	logic [TAG_COUNT-1:0] active_q;
	logic [3:0]           report_q;
	logic                 d3_q;
	logic                 pme_q;
	logic                 idle_ci;
	logic                 idle_sdb;
	logic                 aggr_go;
	logic                 sw_ok;
	logic                 sw_slumber;
	logic                 wake_evt;
	logic                 sdb_wake;

	// allowed field gating
	// Checks a target state against capability and the allowed field.
	function automatic logic state_allowed(input logic slumber, input logic [3:0] ipm);
		logic ok;
		ok = (ipm != IPM_NO_ANY);
		if (slumber) begin
			ok = ok && SLUMBER_CAP && (ipm != IPM_NO_SLUMBER);
		end else begin
			ok = ok && PARTIAL_CAP && (ipm != IPM_NO_PARTIAL);
		end
		return ok;
	endfunction : state_allowed

	assign aggressive_pm_supported = AGGR_SUPPORTED;
	assign partial_capable = PARTIAL_CAP;
	assign slumber_capable = SLUMBER_CAP;
	assign port_multiplier_supported = PMULT_SUPPORTED;
	assign command_based_switching = PMULT_SUPPORTED;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			issued_q <= '0;
			active_q <= '0;
		end else begin
			issued_q <= issued_command_bitmap;
			active_q <= active_tag_bitmap;
		end
	end

	assign idle_ci = (active_tag_bitmap == '0) && (issued_q != '0)
		&& (issued_command_bitmap == '0);
	assign idle_sdb = (issued_command_bitmap == '0) && sdb_received
		&& (active_q != '0) && (active_tag_bitmap == '0);

	assign sw_slumber = (interface_comm_control == ICC_SLUMBER);
	assign sw_ok = icc_write && link_idle && (state_q == LNK_ACTIVE)
		&& (sw_slumber || interface_comm_control == ICC_PARTIAL)
		&& state_allowed(sw_slumber, allowed_power_transitions);

	assign aggr_go = aggr_pend_q && (state_q == LNK_ACTIVE) && link_idle
		&& !fis_tx_request
		&& state_allowed(aggressive_state_select, allowed_power_transitions);

	// arm on transitions
	// Pending aggressive entry, armed only by a true transition to idle.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			aggr_pend_q <= 1'b0;
		end else if (AGGR_SUPPORTED && aggressive_pm_enable && (idle_ci || idle_sdb)) begin
			aggr_pend_q <= 1'b1;
		end else if (aggr_go || !aggressive_pm_enable || issued_command_bitmap != '0) begin
			aggr_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q  <= LNK_ACTIVE;
			target_q <= RST_TARGET;
		end else begin
			case (state_q)
				LNK_ACTIVE: begin
					if (aggr_go) begin
						target_q <= aggressive_state_select;
						state_q  <= LNK_REQUEST;
					end else if (sw_ok) begin
						target_q <= sw_slumber;
						state_q  <= LNK_REQUEST;
					end
				end
				LNK_REQUEST: begin
					if (pm_ack) begin
						state_q <= LNK_LOW;
					end else if (pm_nack) begin
						state_q <= LNK_ACTIVE;
					end
				end
				LNK_LOW: begin
					if (fis_tx_request || (icc_write && interface_comm_control == ICC_ACTIVE)) begin
						state_q <= LNK_WAKE;
					end
				end
				LNK_WAKE: begin
					if (link_active) begin
						state_q <= LNK_ACTIVE;
					end
				end
				default: begin
					state_q <= LNK_ACTIVE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			report_q <= RST_REPORT;
		end else if (state_q == LNK_LOW) begin
			report_q <= target_q ? RPT_SLUMBER : RPT_PARTIAL;
		end else begin
			report_q <= RPT_ACTIVE;
		end
	end

	assign link_pm_report = report_q;
	assign pm_request = (state_q == LNK_REQUEST);
	assign pm_request_slumber = target_q;
	assign comwake_request = (state_q == LNK_WAKE);
	assign fis_tx_go = fis_tx_request && link_active && (state_q == LNK_ACTIVE);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			d3_q <= RST_D3;
		end else if (pmcsr_write) begin
			d3_q <= pmcsr_d3;
		end
	end

	assign power_d3 = d3_q;
	assign mmio_master_abort = mmio_access && d3_q;
	assign mmio_accept = mmio_access && !d3_q;
	assign irq_out = port_irq_pending && global_interrupt_enable && !d3_q;

	assign sdb_wake = sdb_received && sdb_interrupt_bit
		&& (sdb_notify_bit || !WAKE_NEEDS_NOTE);
	assign wake_evt = hotplug_insert_change || presence_switch_change
		|| cold_presence_change || sdb_wake;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pme_q <= 1'b0;
		end else if (d3_q && wake_evt) begin
			pme_q <= 1'b1;
		end else if (pme_status_clear) begin
			pme_q <= 1'b0;
		end
	end

	assign pme_status = pme_q;
	assign pme_n_out = 1'b0;
	assign pme_n_oe = pme_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_aggr_entry: assert property (aggr_go |=> state_q == LNK_REQUEST
		&& target_q == $past(aggressive_state_select))
		else $error("aggressive entry not started");
	a_idle_issued: assert property (idle_ci && AGGR_SUPPORTED
		&& aggressive_pm_enable |=> aggr_pend_q || state_q == LNK_REQUEST)
		else $error("issued idle missed");
	a_idle_sdb: assert property (idle_sdb && AGGR_SUPPORTED
		&& aggressive_pm_enable |=> aggr_pend_q || state_q == LNK_REQUEST)
		else $error("set-bits idle missed");
	a_no_self_entry: assert property (state_q == LNK_ACTIVE
		&& !aggr_pend_q && !sw_ok |=> state_q != LNK_REQUEST)
		else $error("self entry without cause");
	a_wake_first: assert property (state_q == LNK_LOW && fis_tx_request
		|=> comwake_request ##0 !fis_tx_go)
		else $error("no wake before transmit");
	a_hba_wins: assert property (aggr_go && sw_ok
		|=> target_q == $past(aggressive_state_select))
		else $error("software beat adapter");
	a_busy_ignore: assert property (state_q == LNK_ACTIVE
		&& !link_idle |=> state_q == LNK_ACTIVE)
		else $error("request taken while busy");
	a_ipm_block: assert property (allowed_power_transitions == IPM_NO_ANY
		&& state_q == LNK_ACTIVE |=> state_q != LNK_REQUEST)
		else $error("transition while disabled");
	a_nack_stay: assert property (state_q == LNK_REQUEST && pm_nack
		&& !pm_ack |=> state_q == LNK_ACTIVE && !aggr_pend_q)
		else $error("reject not honoured");
	a_d3_abort: assert property (mmio_access && d3_q
		|-> mmio_master_abort && !mmio_accept)
		else $error("access in D3 not aborted");
	a_d3_quiet: assert property (d3_q |-> !irq_out)
		else $error("interrupt in D3");
	a_d3_exit: assert property (pmcsr_write && !pmcsr_d3 |=> !power_d3)
		else $error("D3 exit missed");
	a_pme_raise: assert property (d3_q && hotplug_insert_change
		|=> pme_n_oe [*2])
		else $error("wake not signalled");

endmodule : sata_port_link_power_manager

// File: sata_drive_model.sv
// Behavioural drive at the far side of the link: answers power requests, wakes on COMWAKE.
// Assumes the block's request outputs change only on rising edges of clk_sys.
module sata_drive_model (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic pm_request,
	input  wire logic comwake_request,
	input  wire logic reject,
	output      logic pm_ack,
	output      logic pm_nack,
	output      logic link_active
);
	timeunit 1ns;
	timeprecision 1ps;
	int req_cnt;
	int wake_cnt;
	// the drive never starts a power request of its own.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pm_ack <= 1'b0;
			pm_nack <= 1'b0;
			link_active <= 1'b1;
			req_cnt <= 0;
			wake_cnt <= 0;
		end else begin
			pm_ack <= 1'b0;
			pm_nack <= 1'b0;
			if (pm_request && !pm_ack && !pm_nack) begin
				req_cnt <= req_cnt + 1;
				if (req_cnt == 2) begin
					req_cnt <= 0;
					pm_ack <= !reject;
					pm_nack <= reject;
					if (!reject) link_active <= 1'b0;
				end
			end
			// link comes up a few cycles after COMWAKE.
			if (comwake_request && !link_active) begin
				wake_cnt <= wake_cnt + 1;
				if (wake_cnt == 3) begin
					link_active <= 1'b1;
					wake_cnt <= 0;
				end
			end
		end
	end
endmodule : sata_drive_model

// File: test_sata_port_link_power_manager.sv
// Self-checking bench for the port link power manager with a drive model.
// Assumes 25 MHz clk_sys and inputs changed 1 ns after each rising edge.
module test_sata_port_link_power_manager;
	import sata_lpm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, arst_n = 0, aggressive_pm_enable = 0, aggressive_state_select = 0;
	logic [3:0] allowed_power_transitions = 4'h0, interface_comm_control = 4'h0;
	logic icc_write = 0, sdb_received = 0, sdb_interrupt_bit = 0, sdb_notify_bit = 0;
	logic [31:0] active_tag_bitmap = 32'h0, issued_command_bitmap = 32'h0;
	logic link_idle = 1, fis_tx_request = 0, pmcsr_write = 0, pmcsr_d3 = 0, reject = 0;
	logic mmio_access = 0, global_interrupt_enable = 0, port_irq_pending = 0;
	logic [2:0] ev = 3'h0;
	logic pme_status_clear = 0, link_active, pm_ack, pm_nack, pm_request, pm_request_slumber;
	logic comwake_request, fis_tx_go, power_d3, mmio_accept, mmio_master_abort, irq_out;
	logic aggressive_pm_supported, partial_capable, slumber_capable, port_multiplier_supported;
	logic command_based_switching, pme_status, pme_n_out, pme_n_oe, hotplug_insert_change;
	logic presence_switch_change, cold_presence_change, seen;
	logic [3:0] link_pm_report;
	int err_total = 0, compares = 0, i;
	assign hotplug_insert_change = ev[0];
	assign presence_switch_change = ev[1];
	assign cold_presence_change = ev[2];
	always #20 clk_sys = ~clk_sys;
	sata_port_link_power_manager dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.aggressive_pm_supported(aggressive_pm_supported), .partial_capable(partial_capable),
		.slumber_capable(slumber_capable), .port_multiplier_supported(port_multiplier_supported),
		.command_based_switching(command_based_switching),
		.aggressive_pm_enable(aggressive_pm_enable),
		.aggressive_state_select(aggressive_state_select),
		.allowed_power_transitions(allowed_power_transitions),
		.interface_comm_control(interface_comm_control), .icc_write(icc_write),
		.active_tag_bitmap(active_tag_bitmap), .issued_command_bitmap(issued_command_bitmap),
		.sdb_received(sdb_received), .sdb_interrupt_bit(sdb_interrupt_bit),
		.sdb_notify_bit(sdb_notify_bit), .link_idle(link_idle), .link_active(link_active),
		.pm_ack(pm_ack), .pm_nack(pm_nack), .pm_request(pm_request),
		.pm_request_slumber(pm_request_slumber), .comwake_request(comwake_request),
		.link_pm_report(link_pm_report), .fis_tx_request(fis_tx_request),
		.fis_tx_go(fis_tx_go), .pmcsr_write(pmcsr_write), .pmcsr_d3(pmcsr_d3),
		.power_d3(power_d3), .mmio_access(mmio_access), .mmio_accept(mmio_accept),
		.mmio_master_abort(mmio_master_abort),
		.global_interrupt_enable(global_interrupt_enable),
		.port_irq_pending(port_irq_pending), .irq_out(irq_out),
		.hotplug_insert_change(hotplug_insert_change),
		.presence_switch_change(presence_switch_change),
		.cold_presence_change(cold_presence_change), .pme_status_clear(pme_status_clear),
		.pme_status(pme_status), .pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe));
	sata_drive_model drive (.clk_sys(clk_sys), .arst_n(arst_n), .pm_request(pm_request),
		.comwake_request(comwake_request), .reject(reject), .pm_ack(pm_ack),
		.pm_nack(pm_nack), .link_active(link_active));
	task tick;
		@(posedge clk_sys);
		#1;
	endtask : tick
	task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task quiet(input int n);
		seen = 0;
		repeat (n) begin
			tick;
			if (pm_request !== 1'b0) seen = 1;
		end
	endtask : quiet
	task icc(input logic [3:0] code);
		interface_comm_control = code;
		icc_write = 1;
		tick;
		icc_write = 0;
	endtask : icc
	task wait_report(input logic [3:0] code);
		for (i = 0; i < 40 && link_pm_report !== code; i++) tick;
	endtask : wait_report
	task wake_done;
		for (i = 0; i < 20 && comwake_request !== 1'b0; i++) tick;
		chk("woken", 4'h1, link_active);
		chk("act_report", RPT_ACTIVE, link_pm_report);
	endtask : wake_done
	task t_aggr_slumber;
		aggressive_pm_enable = 1;
		aggressive_state_select = 1;
		issued_command_bitmap = 32'h1;
		repeat (2) tick;
		issued_command_bitmap = 32'h0;
		tick;
		icc(ICC_PARTIAL);
		for (i = 0; i < 10 && pm_request !== 1'b1; i++) tick;
		chk("req", 4'h1, pm_request);
		chk("slumber", 4'h1, pm_request_slumber);
		wait_report(RPT_SLUMBER);
		chk("report", RPT_SLUMBER, link_pm_report);
		fis_tx_request = 1;
		tick;
		for (i = 0; i < 10 && comwake_request !== 1'b1; i++) tick;
		chk("wake", 4'h1, comwake_request);
		chk("go_early", 4'h0, fis_tx_go);
		for (i = 0; i < 20 && fis_tx_go !== 1'b1; i++) tick;
		chk("go_active", 4'h3, {fis_tx_go, link_active});
		fis_tx_request = 0;
		$display("test aggr_slumber done");
	endtask : t_aggr_slumber
	task t_sdb_partial;
		aggressive_state_select = 0;
		active_tag_bitmap = 32'h5;
		repeat (2) tick;
		active_tag_bitmap = 32'h0;
		sdb_received = 1;
		tick;
		sdb_received = 0;
		for (i = 0; i < 10 && pm_request !== 1'b1; i++) tick;
		chk("sdb_req", 4'h2, {pm_request, pm_request_slumber});
		wait_report(RPT_PARTIAL);
		chk("sdb_report", RPT_PARTIAL, link_pm_report);
		icc(ICC_SLUMBER);
		quiet(5);
		chk("no_direct", 4'h0, seen);
		chk("still_partial", RPT_PARTIAL, link_pm_report);
		icc(ICC_ACTIVE);
		wake_done;
		$display("test sdb_partial done");
	endtask : t_sdb_partial
	task t_software;
		quiet(10);
		chk("no_self", 4'h0, seen);
		allowed_power_transitions = IPM_NO_ANY;
		icc(ICC_SLUMBER);
		quiet(5);
		chk("ipm_block", 4'h0, seen);
		allowed_power_transitions = IPM_ALLOW_ALL;
		link_idle = 0;
		icc(ICC_SLUMBER);
		quiet(5);
		chk("busy_link", 4'h0, seen);
		link_idle = 1;
		icc(ICC_SLUMBER);
		for (i = 0; i < 10 && pm_request !== 1'b1; i++) tick;
		chk("sw_slumber", 4'h3, {pm_request, pm_request_slumber});
		wait_report(RPT_SLUMBER);
		chk("sw_report", RPT_SLUMBER, link_pm_report);
		icc(ICC_ACTIVE);
		wake_done;
		$display("test software done");
	endtask : t_software
	task t_nack;
		reject = 1;
		// commands go to one device only.
		issued_command_bitmap = 32'h80000000;
		repeat (2) tick;
		issued_command_bitmap = 32'h0;
		for (i = 0; i < 10 && pm_nack !== 1'b1; i++) tick;
		quiet(12);
		chk("no_retry", 4'h0, seen);
		chk("stay_active", RPT_ACTIVE, link_pm_report);
		reject = 0;
		$display("test nack done");
	endtask : t_nack
	task t_d3;
		// interrupts start off before D3, with a port interrupt left pending.
		global_interrupt_enable = 0;
		port_irq_pending = 1;
		chk("caps", 4'hF, {aggressive_pm_supported, partial_capable, slumber_capable,
			port_multiplier_supported});
		chk("caps2", 4'h2, {command_based_switching, pme_n_out});
		pmcsr_d3 = 1;
		pmcsr_write = 1;
		tick;
		pmcsr_write = 0;
		global_interrupt_enable = 1;
		tick;
		mmio_access = 1;
		#1;
		chk("d3_mmio", 4'hC, {power_d3, mmio_master_abort, mmio_accept, irq_out});
		mmio_access = 0;
		for (int k = 0; k < 4; k++) begin
			if (k < 3) ev = 3'h1 << k;
			else {sdb_received, sdb_interrupt_bit} = 2'h3;
			tick;
			{ev, sdb_received, sdb_interrupt_bit} = 5'h00;
			tick;
			chk("pme_set", 4'h3, {pme_status, pme_n_oe});
			pme_status_clear = 1;
			tick;
			pme_status_clear = 0;
			tick;
			chk("pme_clr", 4'h0, {pme_status, pme_n_oe});
		end
		pmcsr_d3 = 0;
		pmcsr_write = 1;
		tick;
		pmcsr_write = 0;
		tick;
		chk("d0_irq", 4'h1, {power_d3, irq_out});
		$display("test d3 done");
	endtask : t_d3
	task report_and_stop;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	initial begin
		#200000;
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		arst_n = 1;
		tick;
		t_aggr_slumber;
		t_sdb_partial;
		t_software;
		t_nack;
		t_d3;
		report_and_stop;
	end
endmodule : test_sata_port_link_power_manager
